//--- logic/tms_sequencer.sv
// module: terminal mode decoder, profile runner and preset move sequencer
// How it works
// - open enable input disables motor control; motor coasts free.
// - profile forward runs only while forward input closed; else decelerate only under keypad source with keypad forward on.
// - profile reverse runs only while reverse input closed; else decelerate only under keypad source with keypad reverse on.
// - seven profiles; curve n uses preset speed n.
// - continuous input closed: count reached clears counter, profile restarts.
// - continuous input open: cycling ends when count is reached.
// - run source closed uses direction inputs, open uses keypad commands.
// - profile reset input closed clears pending alarm or fault.
// - trip enabled and trip input open gives external trip fault.
// - preset position mode only allowed under closed loop vector control.
// - position mode chosen by operating mode equal to position value.
// - select code 0 home, 1-6 absolute, 7-14 incremental targets.
// - all four select inputs closed acts as fault reset.
// - trigger closure starts the currently selected move.
// - profile select closed uses group and speed one, open two.
// - absolute move travels target minus present position, no homing.
// - incremental move travels exactly the selected distance.
// - home move drives forward until home reached and motor stopped.
// - abort by opening direction inputs; restart needs direction and trigger.
// - both direction inputs open in position mode decelerates to stop.
// - at-position asserts within band of target (home move: home reached), clears when that ends or on new trigger.
// - in-motion asserts on accepted trigger, clears at target and stopped.
`timescale 1ns/1ps
`default_nettype none
module tms_sequencer
  import tms_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          drive_enable_in,
  input  wire logic                          forward_dir_in,
  input  wire logic                          reverse_dir_in,
  input  wire logic                          cycle_or_select0_in,
  input  wire logic                          runsrc_or_select1_in,
  input  wire logic                          position_select2_in,
  input  wire logic                          position_select3_in,
  input  wire logic                          reset_or_profile_select_in,
  input  wire logic                          trip_or_trigger_in,
  input  wire logic [1:0]                    op_mode,
  input  wire logic                          closed_loop_vector,
  input  wire logic                          ext_trip_enable,
  input  wire logic                          keypad_fwd,
  input  wire logic                          keypad_rev,
  input  wire logic [tms_pkg::CNT_W-1:0]     cycle_count_cfg,
  input  wire logic                          profile_done,
  input  wire logic [tms_pkg::POS_W-1:0]     preset_target [tms_pkg::NUM_TARGETS],
  input  wire logic [tms_pkg::POS_W-1:0]     present_pos,
  input  wire logic                          home_reached,
  input  wire logic                          motor_stopped,
  input  wire logic [tms_pkg::BAND_W-1:0]    at_pos_band,
  input  wire logic                          fault_in,
  output var  logic                          motor_enable,
  output var  logic                          run_fwd,
  output var  logic                          run_rev,
  output var  logic                          decel_stop,
  output var  logic [2:0]                    speed_curve,
  output var  logic [tms_pkg::CNT_W-1:0]     cycle_count,
  output var  logic                          profile_running,
  output var  logic                          fault_clear,
  output var  logic                          ext_trip_fault,
  output var  logic                          move_start,
  output var  tms_pkg::tms_move_t            move_type,
  output var  logic [tms_pkg::POS_W-1:0]     move_distance,
  output var  logic [tms_pkg::POS_W-1:0]     move_target,
  output var  logic                          group_one,
  output var  logic                          at_position,
  output var  logic                          in_motion
);
  import tms_pkg::*;

  tms_in_if in_q ();
  logic [NUM_IN-1:0] lvl;

  tms_debounce u_db (
    .clk  (clk),
    .nrst (nrst),
    .raw  ({trip_or_trigger_in, reset_or_profile_select_in,
            position_select3_in, position_select2_in,
            runsrc_or_select1_in, cycle_or_select0_in,
            reverse_dir_in, forward_dir_in, drive_enable_in}),
    .q    (in_q)
  );
  assign lvl = in_q.lvl;

  function automatic logic [POS_W-1:0] pos_diff(
    input logic [POS_W-1:0] a,
    input logic [POS_W-1:0] b
  );
    pos_diff = a - b;
  endfunction

  function automatic logic [POS_W-1:0] abs_val(input logic [POS_W-1:0] v);
    abs_val = v[POS_W-1] ? pos_diff('0, v) : v;
  endfunction

  tms_mode_t mode;
  logic      en, fwd, rev, trig_r, trig_rise, fault_sel;
  logic [3:0] sel;

  assign en  = lvl[IN_ENABLE];
  assign fwd = lvl[IN_FWD];
  assign rev = lvl[IN_REV];
  assign sel = {lvl[IN_SEL3], lvl[IN_SEL2], lvl[IN_SEL1], lvl[IN_SEL0]};
  assign fault_sel = (sel == SEL_FAULT_RESET);

  // position mode needs vector control, otherwise nothing runs
  always_comb begin
    if (op_mode == 2'(TMS_MODE_POSITION) && closed_loop_vector) begin
      mode = TMS_MODE_POSITION;
    end else if (op_mode == 2'(TMS_MODE_PROFILE)) begin
      mode = TMS_MODE_PROFILE;
    end else begin
      mode = TMS_MODE_OFF;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) trig_r <= 1'b0;
    else       trig_r <= lvl[IN_TRIP_TRIG];
  end
  assign trig_rise = lvl[IN_TRIP_TRIG] && !trig_r;

  // drive enable and trip
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      motor_enable   <= 1'b0;
      ext_trip_fault <= 1'b0;
    end else begin
      motor_enable   <= en && !ext_trip_fault;
      if (mode == TMS_MODE_PROFILE && ext_trip_enable && !lvl[IN_TRIP_TRIG])
        ext_trip_fault <= 1'b1;
      else if (fault_clear)
        ext_trip_fault <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) fault_clear <= 1'b0;
    else if (mode == TMS_MODE_PROFILE)
      fault_clear <= lvl[IN_RST_PSEL];
    else if (mode == TMS_MODE_POSITION)
      fault_clear <= fault_sel;
    else
      fault_clear <= 1'b0;
  end

  // profile run: curve steps 1..7, cycle counter when the curve 7 profile ends
  logic cmd_fwd, cmd_rev, cycling_done;
  assign cmd_fwd = lvl[IN_SEL1] ? fwd : keypad_fwd;
  assign cmd_rev = lvl[IN_SEL1] ? rev : keypad_rev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      speed_curve  <= CURVE_FIRST;
      cycle_count  <= CYCLE_RESET;
      cycling_done <= 1'b0;
    end else if (mode != TMS_MODE_PROFILE || !en) begin
      speed_curve  <= CURVE_FIRST;
      cycle_count  <= CYCLE_RESET;
      cycling_done <= 1'b0;
    end else if (profile_done && !cycling_done) begin
      if (speed_curve != CURVE_LAST) begin
        speed_curve <= speed_curve + 3'h1;
      end else begin
        speed_curve <= CURVE_FIRST;
        if (cycle_count + 16'h1 >= cycle_count_cfg) begin
          cycle_count  <= CYCLE_RESET;
          cycling_done <= !lvl[IN_SEL0];
        end else begin
          cycle_count <= cycle_count + 16'h1;
        end
      end
    end
  end

  // position mode move sequencing
  logic       moving_r;
  logic       psel_r;
  logic [3:0] sel_r;
  logic [POS_W-1:0] err;
  assign err = pos_diff(move_target, present_pos);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      move_start    <= 1'b0;
      move_type     <= TMS_MOVE_NONE;
      move_distance <= '0;
      move_target   <= '0;
      sel_r         <= SEL_HOME;
      psel_r        <= 1'b1;
    end else begin
      move_start <= 1'b0;
      // new move only with a direction closed; abort needs a fresh trigger
      if (mode == TMS_MODE_POSITION && en && trig_rise && (fwd || rev) &&
          !fault_sel) begin
        move_start <= 1'b1;
        sel_r      <= sel;
        psel_r     <= lvl[IN_RST_PSEL];
        if (sel == SEL_HOME) begin
          move_type     <= TMS_MOVE_HOME;
          move_target   <= '0;
          move_distance <= pos_diff('0, present_pos);
        end else if (sel <= SEL_ABS_LAST) begin
          move_type     <= TMS_MOVE_ABS;
          move_target   <= preset_target[sel - 4'h1];
          move_distance <= pos_diff(preset_target[sel - 4'h1],
                                    present_pos);
        end else begin
          move_type     <= TMS_MOVE_INC;
          move_target   <= present_pos + preset_target[sel - 4'h1];
          move_distance <= preset_target[sel - 4'h1];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) group_one <= 1'b1;
    else if (mode == TMS_MODE_POSITION) group_one <= psel_r;
    else group_one <= 1'b1;
  end

  logic reached;
  assign reached = (move_type == TMS_MOVE_HOME) ? home_reached :
                   (abs_val(err) <= POS_W'(at_pos_band));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      moving_r    <= 1'b0;
      in_motion   <= 1'b0;
      at_position <= 1'b0;
    end else if (mode != TMS_MODE_POSITION) begin
      moving_r    <= 1'b0;
      in_motion   <= 1'b0;
      at_position <= 1'b0;
    end else if (move_start) begin
      moving_r    <= 1'b1;
      in_motion   <= 1'b1;
      at_position <= 1'b0;
    end else begin
      if (moving_r && (!fwd && !rev || !en)) moving_r <= 1'b0;
      if (reached && move_type != TMS_MOVE_NONE) begin
        at_position <= 1'b1;
        if (motor_stopped) begin
          in_motion <= 1'b0;
          moving_r  <= 1'b0;
        end
      end else begin
        at_position <= 1'b0;
      end
    end
  end

  // direction drive for both modes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_fwd         <= 1'b0;
      run_rev         <= 1'b0;
      decel_stop      <= 1'b0;
      profile_running <= 1'b0;
    end else if (!en || ext_trip_fault || fault_in) begin
      run_fwd         <= 1'b0;
      run_rev         <= 1'b0;
      decel_stop      <= 1'b0;
      profile_running <= 1'b0;
    end else if (mode == TMS_MODE_PROFILE) begin
      run_fwd         <= cmd_fwd && fwd && !cycling_done;
      run_rev         <= cmd_rev && rev && !cycling_done;
      decel_stop      <= (cmd_fwd && !fwd) || (cmd_rev && !rev);
      profile_running <= (cmd_fwd && fwd || cmd_rev && rev) && !cycling_done;
    end else if (mode == TMS_MODE_POSITION) begin
      // home always forward; others head toward the target
      run_fwd    <= moving_r && fwd && (move_type == TMS_MOVE_HOME ||
                    !err[POS_W-1]);
      run_rev    <= moving_r && rev && move_type != TMS_MOVE_HOME &&
                    err[POS_W-1];
      decel_stop <= !fwd && !rev;
      profile_running <= 1'b0;
    end else begin
      run_fwd         <= 1'b0;
      run_rev         <= 1'b0;
      decel_stop      <= 1'b0;
      profile_running <= 1'b0;
    end
  end

  a_enable_coast: assert property (@(posedge clk) disable iff (!nrst)
    !en |=> !motor_enable && !run_fwd && !run_rev)
    else $error("motor driven while enable open");

  a_prof_fwd_stop: assert property (@(posedge clk) disable iff (!nrst)
    mode == TMS_MODE_PROFILE && !fwd |=> !run_fwd)
    else $error("profile forward ran with forward input open");
  a_prof_rev_stop: assert property (@(posedge clk) disable iff (!nrst)
    mode == TMS_MODE_PROFILE && !rev |=> !run_rev)
    else $error("profile reverse ran with reverse input open");
  a_curve_range: assert property (@(posedge clk) disable iff (!nrst)
    speed_curve >= CURVE_FIRST && speed_curve <= CURVE_LAST)
    else $error("speed curve out of range");
  a_done_halts: assert property (@(posedge clk) disable iff (!nrst)
    mode == TMS_MODE_PROFILE && cycling_done
    |=> !run_fwd && !run_rev && !profile_running)
    else $error("profile kept running after cycling ended");
  a_reset_input: assert property (@(posedge clk) disable iff (!nrst)
    mode == TMS_MODE_PROFILE && lvl[IN_RST_PSEL] |=> fault_clear)
    else $error("profile reset input did not clear fault");
  a_trip_fault: assert property (@(posedge clk) disable iff (!nrst)
    mode == TMS_MODE_PROFILE && ext_trip_enable && !lvl[IN_TRIP_TRIG]
    |=> ext_trip_fault)
    else $error("external trip not flagged");

  a_mode_vector: assert property (@(posedge clk) disable iff (!nrst)
    !closed_loop_vector |=> !move_start)
    else $error("move started without vector control");
  a_fault_sel: assert property (@(posedge clk) disable iff (!nrst)
    mode == TMS_MODE_POSITION && fault_sel |=> fault_clear && !move_start)
    else $error("all-closed select did not reset fault");
  sequence s_trig_ok;
    mode == TMS_MODE_POSITION && en && trig_rise && (fwd || rev) && !fault_sel;
  endsequence
  sequence s_started;
    move_start ##1 in_motion && !at_position;
  endsequence
  a_trig_start: assert property (@(posedge clk)
    disable iff (!nrst) s_trig_ok |=> s_started)
    else $error("trigger did not start move");
  // target is built from the position seen at the trigger edge
  a_inc_dist: assert property (@(posedge clk) disable iff (!nrst)
    move_start && move_type == TMS_MOVE_INC
    |-> move_target == $past(present_pos) + move_distance)
    else $error("incremental target mismatch");
  a_move_latch: assert property (@(posedge clk) disable iff (!nrst)
    !move_start |-> $stable(move_target) && $stable(move_type))
    else $error("move changed without a new trigger");
  a_stop_clears: assert property (@(posedge clk) disable iff (!nrst)
    mode == TMS_MODE_POSITION && !move_start && reached &&
    move_type != TMS_MOVE_NONE && motor_stopped |=> !in_motion)
    else $error("in motion held after target reached and stopped");

  a_both_open: assert property (@(posedge clk) disable iff (!nrst)
    mode == TMS_MODE_POSITION && en && !fwd && !rev && !ext_trip_fault &&
    !fault_in |=> decel_stop && !run_fwd && !run_rev)
    else $error("both directions open did not stop");
endmodule
`default_nettype wire

//--- logic/tms_pkg.sv
// package: constants and types for the terminal mode move sequencer
package tms_pkg;
  localparam int unsigned  CLK_MHZ          = 100;
  localparam int unsigned  DEBOUNCE_US      = 1;
  localparam int unsigned  DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned  DB_W             = 8;
  localparam int unsigned  NUM_IN           = 9;
  localparam int unsigned  POS_W            = 32;
  localparam int unsigned  CNT_W            = 16;
  localparam int unsigned  BAND_W           = 16;
  localparam int unsigned  NUM_SPEEDS       = 7;
  localparam int unsigned  NUM_TARGETS      = 14;
  localparam logic [3:0]   SEL_HOME         = 4'h0;
  localparam logic [3:0]   SEL_ABS_LAST     = 4'h6;
  localparam logic [3:0]   SEL_FAULT_RESET  = 4'hf;
  localparam logic [2:0]   CURVE_FIRST      = 3'h1;
  localparam logic [2:0]   CURVE_LAST       = 3'h7;
  localparam logic [CNT_W-1:0] CYCLE_RESET  = 16'h0000;
  // bit positions of the debounced input vector
  localparam int unsigned  IN_ENABLE        = 0;
  localparam int unsigned  IN_FWD           = 1;
  localparam int unsigned  IN_REV           = 2;
  localparam int unsigned  IN_SEL0          = 3;
  localparam int unsigned  IN_SEL1          = 4;
  localparam int unsigned  IN_SEL2          = 5;
  localparam int unsigned  IN_SEL3          = 6;
  localparam int unsigned  IN_RST_PSEL      = 7;
  localparam int unsigned  IN_TRIP_TRIG     = 8;
  typedef enum logic [1:0] {
    TMS_MODE_OFF,
    TMS_MODE_PROFILE,
    TMS_MODE_POSITION
  } tms_mode_t;
  typedef enum logic [1:0] {
    TMS_MOVE_NONE,
    TMS_MOVE_HOME,
    TMS_MOVE_ABS,
    TMS_MOVE_INC
  } tms_move_t;
endpackage

//--- logic/tms_in_if.sv
// interface: debounced terminal levels between filter and sequencer
`timescale 1ns/1ps
`default_nettype none
interface tms_in_if;
  logic [tms_pkg::NUM_IN-1:0] lvl;
  modport filt (output lvl);
  modport seq  (input lvl);
endinterface
`default_nettype wire

//--- logic/tms_debounce.sv
// module: input synchroniser and debounce filter for terminal inputs
`timescale 1ns/1ps
`default_nettype none
module tms_debounce
  import tms_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [NUM_IN-1:0]  raw,
  tms_in_if.filt                  q
);
  logic [NUM_IN-1:0] s1_r;
  logic [NUM_IN-1:0] s2_r;
  logic [NUM_IN-1:0] lvl_r;
  logic [DB_W-1:0]   cnt_r [NUM_IN];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  // a level must hold steady for the full count before it is accepted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lvl_r <= '0;
      for (int i = 0; i < NUM_IN; i++) cnt_r[i] <= '0;
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (s2_r[i] == lvl_r[i]) begin
          cnt_r[i] <= '0;
        end else if (cnt_r[i] == DB_W'(DEBOUNCE_CYC - 1)) begin
          cnt_r[i] <= '0;
          lvl_r[i] <= s2_r[i];
        end else begin
          cnt_r[i] <= cnt_r[i] + DB_W'(1);
        end
      end
    end
  end

  assign q.lvl = lvl_r;

  a_db_stable: assert property (@(posedge clk) disable iff (!nrst)
    $changed(lvl_r) |-> $past(s2_r) == lvl_r)
    else $error("debounced level changed without matching input");
endmodule
`default_nettype wire

//--- verif/tms_switch_model.sv
// partner: terminal switch bank whose contacts chatter on every change
`timescale 1ns/1ps
`default_nettype none
module tms_switch_model
  import tms_pkg::*;
(
  input  wire logic [tms_pkg::NUM_IN-1:0] want,
  output var  logic [tms_pkg::NUM_IN-1:0] pins
);
  logic [NUM_IN-1:0] last_r;
  // chatter lasts about 15 cycles, far inside the filter window;
  // the final copy of want also picks up changes made mid-chatter
  initial begin
    pins = '0;
    last_r = '0;
    forever begin
      @(want);
      repeat (3) begin
        pins = want;
        #20;
        pins = last_r;
        #30;
      end
      pins = want;
      last_r = want;
    end
  end
endmodule
`default_nettype wire

//--- verif/terminal_mode_move_sequencer_test.sv
// testbench: terminal mode move sequencer, profile and preset moves
`timescale 1ns/1ps
`default_nettype none
module terminal_mode_move_sequencer_test;
  import tms_pkg::*;
  localparam int SETTLE = DEBOUNCE_CYC + 30;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [NUM_IN-1:0] want = '0;
  logic [NUM_IN-1:0] pins;
  logic [1:0]        op_mode = 2'h0;
  logic              vec = 1'b0;
  logic              trip_en = 1'b0;
  logic              kp_rev = 1'b0;
  logic              kp_fwd = 1'b0;
  logic              pdone = 1'b0;
  logic [POS_W-1:0]  tgt [NUM_TARGETS];
  logic [POS_W-1:0]  pos = '0;
  logic              home_ok = 1'b0;
  logic              stopped = 1'b0;
  logic              motor_enable, run_fwd, run_rev, decel_stop;
  logic              profile_running, fault_clear, ext_trip_fault;
  logic              move_start, group_one, at_position, in_motion;
  logic [2:0]        speed_curve;
  logic [CNT_W-1:0]  cycle_count;
  tms_move_t         move_type;
  logic [POS_W-1:0]  move_distance, move_target;
  int                err_count = 0;
  int                num_checks = 0;
  int                seed = 99434;

  always #5 clk = ~clk;

  tms_switch_model i_sw (.want(want), .pins(pins));

  tms_sequencer i_dut (
    .clk(clk), .nrst(nrst),
    .drive_enable_in(pins[IN_ENABLE]), .forward_dir_in(pins[IN_FWD]),
    .reverse_dir_in(pins[IN_REV]), .cycle_or_select0_in(pins[IN_SEL0]),
    .runsrc_or_select1_in(pins[IN_SEL1]),
    .position_select2_in(pins[IN_SEL2]),
    .position_select3_in(pins[IN_SEL3]),
    .reset_or_profile_select_in(pins[IN_RST_PSEL]),
    .trip_or_trigger_in(pins[IN_TRIP_TRIG]),
    .op_mode(op_mode), .closed_loop_vector(vec),
    .ext_trip_enable(trip_en), .keypad_fwd(kp_fwd), .keypad_rev(kp_rev),
    .cycle_count_cfg(16'h0002), .profile_done(pdone),
    .preset_target(tgt), .present_pos(pos), .home_reached(home_ok),
    .motor_stopped(stopped), .at_pos_band(16'h000a), .fault_in(1'b0),
    .motor_enable(motor_enable), .run_fwd(run_fwd), .run_rev(run_rev),
    .decel_stop(decel_stop), .speed_curve(speed_curve),
    .cycle_count(cycle_count), .profile_running(profile_running),
    .fault_clear(fault_clear), .ext_trip_fault(ext_trip_fault),
    .move_start(move_start), .move_type(move_type),
    .move_distance(move_distance), .move_target(move_target),
    .group_one(group_one), .at_position(at_position),
    .in_motion(in_motion)
  );

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // move_start stands one cycle, so it is polled every cycle
  task automatic watch(input int n, inout logic seen);
    for (int i = 0; i < n; i++) begin
      step(1);
      if (move_start === 1'b1) seen = 1'b1;
      if (seen) break;
    end
  endtask

  task automatic fire(output logic seen);
    seen = 1'b0;
    want[IN_TRIP_TRIG] = 1'b1;
    watch(SETTLE, seen);
  endtask

  task automatic unfire;
    want[IN_TRIP_TRIG] = 1'b0;
    step(SETTLE);
  endtask

  task automatic run_curves(input int n, input logic chk);
    for (int k = 0; k < n; k++) begin
      if (chk) chk_word("speed_curve", k % 7 + 1, {29'h0, speed_curve});
      pdone = 1'b1;
      step(1);
      pdone = 1'b0;
      step(2);
    end
  endtask

  function automatic tms_move_t exp_type(input logic [3:0] c);
    if (c == SEL_HOME) return TMS_MOVE_HOME;
    if (c <= SEL_ABS_LAST) return TMS_MOVE_ABS;
    return TMS_MOVE_INC;
  endfunction

  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    logic             seen;
    logic [3:0]       c;
    logic             psel;
    logic [POS_W-1:0] et;
    logic [POS_W-1:0] ed;
    tms_move_t        mt;
    for (int i = 0; i < NUM_TARGETS; i++) tgt[i] = $random(seed);
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    chk_bit("motor_enable", 1'b0, motor_enable);
    chk_word("speed_curve", 32'h1, {29'h0, speed_curve});
    chk_bit("group_one", 1'b1, group_one);
    chk_bit("in_motion", 1'b0, in_motion);
    // profile mode, run command from the direction inputs
    op_mode = 2'h1;
    want = 9'h11b;
    step(SETTLE);
    // trip armed only once its pin has settled closed
    trip_en = 1'b1;
    chk_bit("motor_enable", 1'b1, motor_enable);
    chk_bit("run_fwd", 1'b1, run_fwd);
    run_curves(7, 1'b1);
    chk_word("cycle_count", 32'h1, {16'h0, cycle_count});
    run_curves(7, 1'b1);
    chk_word("cycle_count", 32'h0, {16'h0, cycle_count});
    chk_bit("profile_running", 1'b1, profile_running);
    want[IN_SEL0] = 1'b0;
    step(SETTLE);
    run_curves(14, 1'b0);
    chk_bit("profile_running", 1'b0, profile_running);
    // a finished run restarts through a mode change, an open enable or reset
    op_mode = 2'h0;
    step(1);
    op_mode = 2'h1;
    want[IN_FWD] = 1'b0;
    step(SETTLE);
    chk_bit("run_fwd", 1'b0, run_fwd);
    want[IN_REV] = 1'b1;
    step(SETTLE);
    chk_bit("run_rev", 1'b1, run_rev);
    want[IN_SEL1] = 1'b0;
    step(SETTLE);
    chk_bit("run_rev", 1'b0, run_rev);
    kp_rev = 1'b1;
    step(5);
    chk_bit("run_rev", 1'b1, run_rev);
    // keypad command present while its direction input is open
    kp_fwd = 1'b1;
    step(5);
    chk_bit("decel_stop", 1'b1, decel_stop);
    kp_fwd = 1'b0;
    want[IN_REV] = 1'b0;
    step(SETTLE);
    chk_bit("decel_stop", 1'b1, decel_stop);
    kp_rev = 1'b0;
    want[IN_SEL1] = 1'b1;
    want[IN_RST_PSEL] = 1'b1;
    step(SETTLE);
    chk_bit("fault_clear", 1'b1, fault_clear);
    want[IN_RST_PSEL] = 1'b0;
    want[IN_TRIP_TRIG] = 1'b0;
    step(SETTLE);
    chk_bit("ext_trip_fault", 1'b1, ext_trip_fault);
    want[IN_ENABLE] = 1'b0;
    step(SETTLE);
    chk_bit("motor_enable", 1'b0, motor_enable);
    trip_en = 1'b0;
    want[IN_RST_PSEL] = 1'b1;
    step(SETTLE);
    chk_bit("ext_trip_fault", 1'b0, ext_trip_fault);
    // preset position mode, every move code in turn
    op_mode = 2'h2;
    vec = 1'b1;
    want = 9'h003;
    step(SETTLE);
    for (int i = 0; i < 15; i++) begin
      c = i[3:0];
      psel = 1'($random(seed));
      want[IN_SEL3:IN_SEL0] = c;
      want[IN_RST_PSEL] = psel;
      pos = $random(seed);
      mt = exp_type(c);
      step(SETTLE);
      if (mt == TMS_MOVE_ABS) begin
        et = tgt[c-1];
        ed = et - pos;
      end else if (mt == TMS_MOVE_INC) begin
        ed = tgt[c-1];
        et = pos + ed;
      end
      fire(seen);
      chk_bit("move_start", 1'b1, seen);
      chk_word("move_type", {30'h0, mt}, {30'h0, move_type});
      if (c != SEL_HOME) begin
        chk_word("move_target", et, move_target);
        chk_word("move_distance", ed, move_distance);
      end
      step(1);
      chk_bit("group_one", psel, group_one);
      chk_bit("in_motion", 1'b1, in_motion);
      chk_bit("at_position", 1'b0, at_position);
      want[IN_SEL3:IN_SEL0] = {1'b0, ~c[2:0]};
      want[IN_RST_PSEL] = ~psel;
      step(SETTLE);
      chk_word("move_type", {30'h0, mt}, {30'h0, move_type});
      chk_bit("group_one", psel, group_one);
      if (c == SEL_HOME) chk_bit("run_fwd", 1'b1, run_fwd);
      home_ok = (c == SEL_HOME);
      if (c != SEL_HOME) pos = et - 32'h3;
      stopped = 1'b1;
      step(3);
      chk_bit("in_motion", 1'b0, in_motion);
      chk_bit("at_position", 1'b1, at_position);
      stopped = 1'b0;
      home_ok = 1'b0;
      unfire;
    end
    // a trigger shorter than the filter window is ignored
    want[IN_SEL3:IN_SEL0] = 4'h1;
    step(SETTLE);
    seen = 1'b0;
    want[IN_TRIP_TRIG] = 1'b1;
    watch(50, seen);
    want[IN_TRIP_TRIG] = 1'b0;
    watch(SETTLE, seen);
    chk_bit("move_start", 1'b0, seen);
    // abort, refused restart, then a proper restart
    fire(seen);
    want[IN_FWD] = 1'b0;
    step(SETTLE);
    chk_bit("decel_stop", 1'b1, decel_stop);
    // an aborted move never reached its target, so it stays in motion
    chk_bit("in_motion", 1'b1, in_motion);
    unfire;
    fire(seen);
    chk_bit("move_start", 1'b0, seen);
    unfire;
    want[IN_FWD] = 1'b1;
    step(SETTLE);
    fire(seen);
    chk_bit("move_start", 1'b1, seen);
    unfire;
    want[IN_SEL3:IN_SEL0] = SEL_FAULT_RESET;
    step(SETTLE);
    chk_bit("fault_clear", 1'b1, fault_clear);
    fire(seen);
    chk_bit("move_start", 1'b0, seen);
    unfire;
    vec = 1'b0;
    want[IN_SEL3:IN_SEL0] = 4'h2;
    step(SETTLE);
    fire(seen);
    chk_bit("move_start", 1'b0, seen);
    unfire;
    vec = 1'b1;
    op_mode = 2'h1;
    step(SETTLE);
    fire(seen);
    chk_bit("move_start", 1'b0, seen);
    tally_and_finish();
  end
endmodule
`default_nettype wire
